// ===== shared/frame_pkg.sv
package frame_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [8:0]  len_t;
  typedef logic [11:0] apb_addr_t;
  typedef enum logic [0:0] {
    SND_IDLE = 1'b0,
    SND_BUSY = 1'b1
  } snd_state_t;
  // Layout numbers, both reached as attribute 3
  localparam byte_t LAYOUT_IO   = 8'h78;
  localparam byte_t LAYOUT_NOIO = 8'h79;
  localparam byte_t LAYOUT_ATTR = 8'h03;
  localparam len_t  MAX_LEN_IO   = 9'd263;
  localparam len_t  MAX_LEN_NOIO = 9'd262;
  localparam len_t  HDR_IO       = 9'd8;
  localparam len_t  HDR_NOIO     = 9'd7;
  // Byte positions in the layout without monitoring; POS_IOMON is the monitoring byte of layout 120
  localparam len_t  POS_CTRL  = 9'd0;
  localparam len_t  POS_IOMON = 9'd1;
  localparam len_t  POS_FNUM  = 9'd1;
  localparam len_t  POS_FREM  = 9'd2;
  localparam len_t  POS_FSIZE = 9'd3;
  localparam len_t  POS_FLAGS = 9'd4;
  localparam len_t  POS_LLO   = 9'd5;
  localparam len_t  POS_LHI   = 9'd6;
  localparam int    CB_ACT = 0;
  localparam int    CB_DACK = 1;
  localparam int    CB_DRST = 2;
  localparam int    CB_EACK = 3;
  localparam int    CB_STBY = 4;
  localparam int    FL_NEWDATA = 0;
  localparam int    FL_NEWENTRY = 1;
  localparam int    CFG_FRAG_BIT = 0;
  localparam logic  CFG_FRAG_RST = 1'b0;
  localparam int    ENTRY_MAX = 255;
  // Controller register map
  localparam apb_addr_t REG_CMD    = 12'h000;
  localparam apb_addr_t REG_CFG    = 12'h004;
  localparam apb_addr_t REG_LEN    = 12'h008;
  localparam apb_addr_t REG_CTRLB  = 12'h00C;
  localparam apb_addr_t REG_IOB    = 12'h010;
  localparam apb_addr_t REG_FRAG   = 12'h014;
  localparam apb_addr_t REG_ENTRY  = 12'h018;
  localparam apb_addr_t REG_STATUS = 12'h01C;
  localparam logic [1:0] DATA_WIN  = 2'h1;
endpackage : frame_pkg

// ===== shared/frame_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface frame_link_if;
  logic             cfg_valid;
  logic             cfg_io_mon;
  logic             cfg_frag;
  logic             fr_valid;
  logic [7:0]       fr_data;
  logic             fr_last;
  modport host (
    output cfg_valid, cfg_io_mon, cfg_frag, fr_valid, fr_data, fr_last
  );
  modport device (
    input  cfg_valid, cfg_io_mon, cfg_frag, fr_valid, fr_data, fr_last
  );
endinterface : frame_link_if
`default_nettype wire

// ===== hdl/frame_decoder.sv
// Summary of operation
// - Host sends frames cyclically; each is current image.
// - Monitoring layout offered as number 120, attribute 3.
// - Layout 120 takes 1 to 263 bytes.
// - Output activation only when output is event-driven.
// - Layout 120 entry data starts at byte 8.
// - Short frames decode control, then monitoring byte only.
// - Host sets length as 8 plus data count.
// - Layout 121 without monitoring, 1 to 262 bytes.
// - Layout 121 bytes 1-4 hold fragment fields, flags.
// - Layout 121 length bytes 5,6; data from 7.
// - One-byte frame acts on control bits only.
// - Entry fragmentation enable from configuration, default off.
`timescale 1ns/10ps
`default_nettype none
module frame_decoder (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Link from the controller
  frame_link_if.device            link,
  // Output function configuration
  input  wire logic [3:0]         ext_event_cfg,
  // Control byte
  output logic                    act_signal,
  output logic                    data_ack,
  output logic                    data_reset,
  output logic                    err_ack,
  output logic                    standby,
  // Switching outputs
  output logic [3:0]              sw_out_act,
  output logic [3:0]              evt_cnt_reset,
  // Fragmentation and entry header
  output frame_pkg::byte_t        frag_num,
  output frame_pkg::byte_t        frag_remain,
  output frame_pkg::byte_t        frag_size,
  output logic                    new_entry,
  output logic                    new_data,
  output logic [15:0]             entry_len,
  output frame_pkg::byte_t        entry_count,
  // Frame status
  output frame_pkg::len_t         frame_len,
  output logic                    frame_done,
  output logic                    len_error,
  output logic                    frag_enable,
  output frame_pkg::byte_t        layout_id,
  // Entry data read port
  input  wire frame_pkg::byte_t   rd_addr,
  output frame_pkg::byte_t        rd_data
);
  import frame_pkg::*;

  byte_t        mem [0:ENTRY_MAX-1];
  len_t         idx;
  len_t         next_idx;
  logic         io_mon;
  logic         next_io_mon;
  logic [3:0]   io_act;
  logic [3:0]   next_io_act;
  logic [4:0]   ctrl;
  logic [4:0]   next_ctrl;
  logic [3:0]   next_evt_cnt_reset;
  logic [3:0]   next_sw_out_act;
  byte_t        next_frag_num;
  byte_t        next_frag_remain;
  byte_t        next_frag_size;
  logic         next_new_entry;
  logic         next_new_data;
  logic [15:0]  next_entry_len;
  byte_t        next_entry_count;
  len_t         next_frame_len;
  logic         next_frame_done;
  logic         next_len_error;
  logic         next_frag_enable;
  len_t         pos;
  len_t         max_len;
  len_t         hdr_len;
  len_t         cnt;
  logic         mem_we;
  byte_t        mem_addr;

  always_comb begin
    next_idx           = idx;
    next_io_mon        = io_mon;
    next_io_act        = io_act;
    next_ctrl          = ctrl;
    next_evt_cnt_reset = evt_cnt_reset;
    next_frag_num      = frag_num;
    next_frag_remain   = frag_remain;
    next_frag_size     = frag_size;
    next_new_entry     = new_entry;
    next_new_data      = new_data;
    next_entry_len     = entry_len;
    next_entry_count   = entry_count;
    next_frame_len     = frame_len;
    next_frame_done    = 1'b0;
    next_len_error     = len_error;
    next_frag_enable   = frag_enable;
    mem_we             = 1'b0;
    mem_addr           = 8'h00;
    max_len            = io_mon ? MAX_LEN_IO : MAX_LEN_NOIO;
    hdr_len            = io_mon ? HDR_IO : HDR_NOIO;
    // Monitoring byte shifts the rest of the header by one
    pos = (io_mon && idx > POS_IOMON) ? idx - 9'd1 : idx;
    cnt = idx + 9'd1;
    // Configuration is only taken between frames
    if (link.cfg_valid && idx == 9'd0) begin
      next_io_mon      = link.cfg_io_mon;
      next_frag_enable = link.cfg_frag;
    end
    if (link.fr_valid) begin
      if (idx == POS_CTRL) begin
        // Fields not carried by a short frame read as absent
        next_io_act        = 4'h0;
        next_evt_cnt_reset = 4'h0;
        next_frag_num      = 8'h00;
        next_frag_remain   = 8'h00;
        next_frag_size     = 8'h00;
        next_new_entry     = 1'b0;
        next_new_data      = 1'b0;
        next_entry_len     = 16'h0000;
        next_len_error     = 1'b0;
        next_ctrl          = link.fr_data[4:0];
      end else if (idx < max_len) begin
        if (io_mon && idx == POS_IOMON) begin
          next_io_act        = {link.fr_data[6], link.fr_data[4],
                                link.fr_data[2], link.fr_data[0]};
          next_evt_cnt_reset = {link.fr_data[7], link.fr_data[5],
                                link.fr_data[3], link.fr_data[1]};
        end else begin
          unique case (pos)
            POS_FNUM:  next_frag_num    = link.fr_data;
            POS_FREM:  next_frag_remain = link.fr_data;
            POS_FSIZE: next_frag_size   = link.fr_data;
            POS_FLAGS: begin
              next_new_data  = link.fr_data[FL_NEWDATA];
              next_new_entry = link.fr_data[FL_NEWENTRY];
            end
            POS_LLO:   next_entry_len[7:0]  = link.fr_data;
            POS_LHI:   next_entry_len[15:8] = link.fr_data;
            default: begin
              mem_we   = 1'b1;
              mem_addr = 8'(idx - hdr_len);
            end
          endcase
        end
      end else begin
        // Bytes past the longest frame are dropped
        next_len_error = 1'b1;
      end
      if (link.fr_last) begin
        next_idx        = 9'd0;
        next_frame_done = 1'b1;
        next_frame_len  = (cnt > max_len) ? max_len : cnt;
        // Data count follows from the number of bytes received in the frame
        next_entry_count = (cnt > hdr_len && cnt <= max_len) ?
                           8'(cnt - hdr_len) :
                           ((cnt > max_len) ? 8'(max_len - hdr_len) : 8'h00);
      end else if (idx != 9'h1FF) begin
        next_idx = cnt;
      end
    end
    // Activation commands only reach event-driven outputs
    next_sw_out_act = next_io_act & ext_event_cfg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx           <= 9'd0;
      io_mon        <= 1'b1;
      io_act        <= 4'h0;
      ctrl          <= 5'h00;
      sw_out_act    <= 4'h0;
      evt_cnt_reset <= 4'h0;
      frag_num      <= 8'h00;
      frag_remain   <= 8'h00;
      frag_size     <= 8'h00;
      new_entry     <= 1'b0;
      new_data      <= 1'b0;
      entry_len     <= 16'h0000;
      entry_count   <= 8'h00;
      frame_len     <= 9'd0;
      frame_done    <= 1'b0;
      len_error     <= 1'b0;
      frag_enable   <= CFG_FRAG_RST;
      layout_id     <= LAYOUT_IO;
    end else begin
      idx           <= next_idx;
      io_mon        <= next_io_mon;
      io_act        <= next_io_act;
      ctrl          <= next_ctrl;
      sw_out_act    <= next_sw_out_act;
      evt_cnt_reset <= next_evt_cnt_reset;
      frag_num      <= next_frag_num;
      frag_remain   <= next_frag_remain;
      frag_size     <= next_frag_size;
      new_entry     <= next_new_entry;
      new_data      <= next_new_data;
      entry_len     <= next_entry_len;
      entry_count   <= next_entry_count;
      frame_len     <= next_frame_len;
      frame_done    <= next_frame_done;
      len_error     <= next_len_error;
      frag_enable   <= next_frag_enable;
      layout_id     <= next_io_mon ? LAYOUT_IO : LAYOUT_NOIO;
    end
  end

  assign act_signal = ctrl[CB_ACT];
  assign data_ack   = ctrl[CB_DACK];
  assign data_reset = ctrl[CB_DRST];
  assign err_ack    = ctrl[CB_EACK];
  assign standby    = ctrl[CB_STBY];

  // Entry store has no reset; entry_count says how much is valid
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_addr] <= link.fr_data;
    end
    rd_data <= (rd_addr < 8'(ENTRY_MAX)) ? mem[rd_addr] : 8'h00;
  end
endmodule : frame_decoder
`default_nettype wire

// ===== hdl/frame_sender.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module frame_sender (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire frame_pkg::apb_addr_t paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Link to the device
  frame_link_if.host              link
);
  import frame_pkg::*;

  byte_t        mem [0:ENTRY_MAX-1];
  snd_state_t   state;
  snd_state_t   next_state;
  logic         cyclic;
  logic         next_cyclic;
  logic         io_mon;
  logic         next_io_mon;
  logic         frag;
  logic         next_frag;
  len_t         len;
  len_t         next_len;
  logic [4:0]   ctrl_b;
  logic [4:0]   next_ctrl_b;
  byte_t        io_b;
  byte_t        next_io_b;
  logic [23:0]  frag_f;
  logic [23:0]  next_frag_f;
  logic [1:0]   flags;
  logic [1:0]   next_flags;
  logic [15:0]  elen;
  logic [15:0]  next_elen;
  len_t         idx;
  len_t         next_idx;
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic         next_cfg_valid;
  logic         next_fr_valid;
  byte_t        next_fr_data;
  logic         next_fr_last;
  logic         wr;
  logic         in_win;
  logic         start;
  len_t         max_len;

  function automatic byte_t byte_at(input len_t i);
    len_t p;
    p = (io_mon && i > POS_IOMON) ? i - 9'd1 : i;
    if (i == POS_CTRL)                  byte_at = {3'h0, ctrl_b};
    else if (io_mon && i == POS_IOMON)  byte_at = io_b;
    else if (p == POS_FNUM)             byte_at = frag_f[7:0];
    else if (p == POS_FREM)             byte_at = frag_f[15:8];
    else if (p == POS_FSIZE)            byte_at = frag_f[23:16];
    else if (p == POS_FLAGS)            byte_at = {6'h00, flags};
    else if (p == POS_LLO)              byte_at = elen[7:0];
    else if (p == POS_LHI)              byte_at = elen[15:8];
    else                                byte_at = mem[8'(p - HDR_NOIO)];
  endfunction : byte_at

  always_comb begin
    wr     = psel && penable && pready && pwrite;
    in_win = paddr[11:10] == DATA_WIN && paddr[9:2] < 8'(ENTRY_MAX);
    max_len = next_io_mon ? MAX_LEN_IO : MAX_LEN_NOIO;
    next_cyclic = cyclic;
    next_io_mon = io_mon;
    next_frag   = frag;
    next_len    = len;
    next_ctrl_b = ctrl_b;
    next_io_b   = io_b;
    next_frag_f = frag_f;
    next_flags  = flags;
    next_elen   = elen;
    start       = 1'b0;
    next_cfg_valid = 1'b0;
    if (wr) begin
      unique case (paddr)
        REG_CMD: begin
          start          = pwdata[0];
          next_cfg_valid = pwdata[1] && state == SND_IDLE;
          next_cyclic    = pwdata[2];
        end
        REG_CFG: begin
          next_io_mon = pwdata[0];
          next_frag   = pwdata[1];
        end
        REG_LEN:   next_len    = pwdata[8:0];
        REG_CTRLB: next_ctrl_b = pwdata[4:0];
        REG_IOB:   next_io_b   = pwdata[7:0];
        REG_FRAG:  next_frag_f = pwdata[23:0];
        REG_ENTRY: begin
          next_flags = pwdata[1:0];
          next_elen  = pwdata[31:16];
        end
        default: ;
      endcase
    end
    // Longest frame depends on the layout in use
    if (next_len > max_len) begin
      next_len = max_len;
    end
    next_pready  = psel && !penable && !pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        REG_CMD:    next_prdata = {29'h0, cyclic, 2'h0};
        REG_CFG:    next_prdata = {30'h0, frag, io_mon};
        REG_LEN:    next_prdata = {23'h0, len};
        REG_CTRLB:  next_prdata = {27'h0, ctrl_b};
        REG_IOB:    next_prdata = {24'h0, io_b};
        REG_FRAG:   next_prdata = {8'h0, frag_f};
        REG_ENTRY:  next_prdata = {elen, 14'h0, flags};
        REG_STATUS: next_prdata = {31'h0, state == SND_BUSY};
        default: begin
          if (in_win) next_prdata = {24'h0, mem[paddr[9:2]]};
          else        next_pslverr = 1'b1;
        end
      endcase
    end
    next_state    = state;
    next_idx      = idx;
    next_fr_valid = 1'b0;
    next_fr_data  = 8'h00;
    next_fr_last  = 1'b0;
    unique case (state)
      SND_IDLE: begin
        // Cyclic mode resends the image after a one-cycle gap
        if ((start || cyclic) && len != 9'd0 && !next_cfg_valid) begin
          next_state    = SND_BUSY;
          next_idx      = 9'd0;
          next_fr_valid = 1'b1;
          next_fr_data  = byte_at(9'd0);
          next_fr_last  = len == 9'd1;
        end
      end
      SND_BUSY: begin
        if (link.fr_last) begin
          next_state = SND_IDLE;
        end else begin
          next_idx      = idx + 9'd1;
          next_fr_valid = 1'b1;
          next_fr_data  = byte_at(idx + 9'd1);
          next_fr_last  = idx + 9'd2 == len;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= SND_IDLE;
      cyclic          <= 1'b0;
      io_mon          <= 1'b1;
      frag            <= CFG_FRAG_RST;
      len             <= 9'd0;
      ctrl_b          <= 5'h00;
      io_b            <= 8'h00;
      frag_f          <= 24'h000000;
      flags           <= 2'h0;
      elen            <= 16'h0000;
      idx             <= 9'd0;
      prdata          <= 32'h0000_0000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      link.cfg_valid  <= 1'b0;
      link.cfg_io_mon <= 1'b1;
      link.cfg_frag   <= CFG_FRAG_RST;
      link.fr_valid   <= 1'b0;
      link.fr_data    <= 8'h00;
      link.fr_last    <= 1'b0;
    end else begin
      state           <= next_state;
      cyclic          <= next_cyclic;
      io_mon          <= next_io_mon;
      frag            <= next_frag;
      len             <= next_len;
      ctrl_b          <= next_ctrl_b;
      io_b            <= next_io_b;
      frag_f          <= next_frag_f;
      flags           <= next_flags;
      elen            <= next_elen;
      idx             <= next_idx;
      prdata          <= next_prdata;
      pready          <= next_pready;
      pslverr         <= next_pslverr;
      link.cfg_valid  <= next_cfg_valid;
      link.cfg_io_mon <= io_mon;
      link.cfg_frag   <= frag;
      link.fr_valid   <= next_fr_valid;
      link.fr_data    <= next_fr_data;
      link.fr_last    <= next_fr_last;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr && in_win) begin
      mem[paddr[9:2]] <= pwdata[7:0];
    end
  end
endmodule : frame_sender
`default_nettype wire

// ===== verification/frame_link_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module frame_link_monitor (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Link signals
  input  wire logic       cfg_valid,
  input  wire logic       cfg_io_mon,
  input  wire logic       cfg_frag,
  input  wire logic       fr_valid,
  input  wire logic [7:0] fr_data,
  input  wire logic       fr_last
);
  logic [8:0] byte_cnt;
  logic [8:0] next_byte_cnt;

  // Bytes already taken in this frame, so the limit is checked before counting
  always_comb begin
    next_byte_cnt = byte_cnt;
    if (fr_valid) begin
      next_byte_cnt = fr_last ? 9'h000 : byte_cnt + 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_cnt <= 9'h000;
    end else begin
      byte_cnt <= next_byte_cnt;
    end
  end

  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_last_with_byte: assert property (fr_last |-> fr_valid)
    else $error("frame end flagged without a byte");
  a_gap_after_last: assert property (fr_valid && fr_last |=> !fr_valid)
    else $error("no idle cycle after a frame");
  a_bytes_back_to_back: assert property (fr_valid && !fr_last |=> fr_valid)
    else $error("hole inside a frame");
  a_cfg_one_pulse: assert property (cfg_valid |=> !cfg_valid)
    else $error("configuration strobe longer than one cycle");
  a_cfg_between_frames: assert property (cfg_valid |-> !fr_valid)
    else $error("configuration sent inside a frame");
  a_layout_steady: assert property (fr_valid && !fr_last |=> $stable(cfg_io_mon))
    else $error("layout changed inside a frame");
  a_len_io_max: assert property (fr_valid && cfg_io_mon |-> byte_cnt < 9'd263)
    else $error("monitoring layout frame too long");
  a_len_noio_max: assert property (fr_valid && !cfg_io_mon |-> byte_cnt < 9'd262)
    else $error("plain layout frame too long");
  a_frame_ends: assert property ($rose(fr_valid) |-> ##[0:262] (fr_valid && fr_last))
    else $error("frame never ended");

  c_single_byte: cover property (fr_valid && fr_last && byte_cnt == 9'h000);
  c_full_io: cover property (fr_valid && fr_last && cfg_io_mon && byte_cnt == 9'd262);
  c_full_noio: cover property (fr_valid && fr_last && !cfg_io_mon && byte_cnt == 9'd261);
  c_cfg_frag_on: cover property (cfg_valid && cfg_frag && fr_data == 8'h00);
endmodule : frame_link_monitor
`default_nettype wire

// ===== verification/cyclic_output_frame_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define chk(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module cyclic_output_frame_decoder_tb;
  import frame_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  apb_addr_t paddr;
  logic [31:0] pwdata, prdata, q;
  logic e, act_signal, data_ack, data_reset, err_ack, standby;
  logic new_entry, new_data, frame_done, len_error, frag_enable;
  logic [3:0] ext_event_cfg, sw_out_act, evt_cnt_reset;
  byte_t frag_num, frag_remain, frag_size, entry_count, layout_id, rd_addr, rd_data;
  logic [15:0] entry_len;
  len_t frame_len;
  byte_t fb[0:262];
  int flen, mismatches, n_compared;
  int lens[10] = '{511, 8, 1, 2, 5, 0, 0, 1, 4, 511};

  frame_link_if link();
  frame_sender frame_sender_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  frame_decoder frame_decoder_i (.pclk(pclk), .presetn(presetn), .link(link),
    .ext_event_cfg(ext_event_cfg), .act_signal(act_signal), .data_ack(data_ack),
    .data_reset(data_reset), .err_ack(err_ack), .standby(standby), .sw_out_act(sw_out_act),
    .evt_cnt_reset(evt_cnt_reset), .frag_num(frag_num), .frag_remain(frag_remain),
    .frag_size(frag_size), .new_entry(new_entry), .new_data(new_data), .entry_len(entry_len),
    .entry_count(entry_count), .frame_len(frame_len), .frame_done(frame_done),
    .len_error(len_error), .frag_enable(frag_enable), .layout_id(layout_id),
    .rd_addr(rd_addr), .rd_data(rd_data));
  frame_link_monitor frame_link_monitor_i (.pclk(pclk), .presetn(presetn),
    .cfg_valid(link.cfg_valid), .cfg_io_mon(link.cfg_io_mon), .cfg_frag(link.cfg_frag),
    .fr_valid(link.fr_valid), .fr_data(link.fr_data), .fr_last(link.fr_last));

  always #50 pclk = ~pclk;

  task automatic apb(input logic wr, input apb_addr_t a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer is taken at the completing edge; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_done;
    for (int i = 0; i < 700; i++) begin
      @(posedge pclk);
      #1;
      if (frame_done === 1'b1) return;
    end
    mismatches++;
    $display("unexpected frame_done expected 1 seen 0");
  endtask : wait_done

  // Absent bytes of a short frame must read as zero
  function automatic byte_t eb(input int p);
    return (p < flen) ? fb[p] : 8'h00;
  endfunction : eb

  task automatic frame(input logic io, input int lenw);
    int o, hdr, nd;
    logic frg;
    byte_t iob;
    o = int'(io);
    hdr = 7 + o;
    flen = (lenw > 262 + o) ? 262 + o : lenw;
    nd = (flen > hdr) ? flen - hdr : 0;
    frg = 1'($urandom);
    foreach (fb[i]) fb[i] = 8'($urandom);
    @(posedge pclk);
    ext_event_cfg <= 4'($urandom);
    apb(1'b1, REG_CFG, {30'h0, frg, io});
    apb(1'b1, REG_CMD, 32'h2);
    apb(1'b1, REG_LEN, 32'(lenw));
    apb(1'b0, REG_LEN, 32'h0);
    `chk("len readback", 32'(flen), q)
    apb(1'b1, REG_CTRLB, {24'h0, fb[0]});
    apb(1'b1, REG_IOB, {24'h0, fb[1]});
    apb(1'b1, REG_FRAG, {8'h0, fb[3+o], fb[2+o], fb[1+o]});
    apb(1'b1, REG_ENTRY, {fb[6+o], fb[5+o], 14'h0, fb[4+o][1:0]});
    for (int i = 0; i < nd; i++) apb(1'b1, 12'h400 + 12'(4 * i), {24'h0, fb[hdr+i]});
    apb(1'b1, REG_CMD, 32'h1);
    wait_done();
    repeat (2) @(posedge pclk);
    #1;
    iob = io ? eb(1) : 8'h00;
    `chk("frag_enable", frg, frag_enable)
    `chk("layout_id", io ? LAYOUT_IO : LAYOUT_NOIO, layout_id)
    `chk("control", fb[0][4:0], {standby, err_ack, data_reset, data_ack, act_signal})
    `chk("sw_out_act", {iob[6], iob[4], iob[2], iob[0]} & ext_event_cfg, sw_out_act)
    `chk("evt_cnt_reset", {iob[7], iob[5], iob[3], iob[1]}, evt_cnt_reset)
    `chk("frag_num", eb(1 + o), frag_num)
    `chk("frag_remain", eb(2 + o), frag_remain)
    `chk("frag_size", eb(3 + o), frag_size)
    `chk("flags", eb(4 + o) & 8'h03, {6'h0, new_entry, new_data})
    `chk("entry_len", {eb(6 + o), eb(5 + o)}, entry_len)
    `chk("entry_count", 8'(nd), entry_count)
    `chk("frame_len", 9'(flen), frame_len)
    `chk("len_error", 1'b0, len_error)
    for (int i = 0; i <= nd; i++) begin
      @(posedge pclk);
      rd_addr <= (i == nd) ? 8'hFF : 8'(i);
      repeat (2) @(posedge pclk);
      #1;
      `chk("entry byte", (i == nd) ? 8'h00 : fb[hdr+i], rd_data)
    end
    @(posedge pclk);
    ext_event_cfg <= 4'h0;
    repeat (2) @(posedge pclk);
    #1;
    `chk("gated outputs", 4'h0, sw_out_act)
  endtask : frame

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_event_cfg = 4'h0;
    rd_addr = 8'h00;
    void'($urandom(8));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    `chk("frag_enable", CFG_FRAG_RST, frag_enable)
    `chk("layout_id", LAYOUT_IO, layout_id)
    apb(1'b0, 12'h300, 32'h0);
    `chk("pslverr", 1'b1, e)
    `chk("prdata", 32'h0, q)
    for (int k = 0; k < 10; k++) frame(k < 6, (lens[k] == 0) ? 9 + int'($urandom % 20) : lens[k]);
    // Cyclic resend: a later write must show up in a following frame
    apb(1'b1, REG_LEN, 32'h1);
    apb(1'b1, REG_CTRLB, 32'h15);
    apb(1'b1, REG_CMD, 32'h4);
    wait_done();
    apb(1'b1, REG_CTRLB, 32'h0A);
    wait_done();
    wait_done();
    `chk("cyclic control", 5'h0A, {standby, err_ack, data_reset, data_ack, act_signal})
    apb(1'b1, REG_CMD, 32'h0);
    report_and_stop();
  end
endmodule : cyclic_output_frame_decoder_tb
`default_nettype wire
